// [ttca_core.sv]
// time tag, coarse and reject counters with trigger fifo
module ttca_core
  import ttca_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             trigger,
  input  wire logic             bunch_reset,
  input  wire logic             event_reset,
  input  wire logic             encoded_control,
  input  wire logic             enable_direct_trigger,
  input  wire logic             enable_direct_bunch_reset,
  input  wire logic             enable_direct_event_reset,
  input  wire logic             enable_master_reset_code,
  input  wire logic             enable_automatic_reject,
  input  wire logic [CNT_W-1:0] coarse_count_offset,
  input  wire logic [CNT_W-1:0] trigger_count_offset,
  input  wire logic [CNT_W-1:0] reject_count_offset,
  input  wire logic [CNT_W-1:0] count_roll_over,
  input  wire logic [CNT_W-1:0] hit_coarse,
  output logic [CNT_W-1:0]      coarse_count,
  output logic [CNT_W-1:0]      hit_ref_count,
  output logic [CNT_W-1:0]      trigger_tag_count,
  output logic [CNT_W-1:0]      reject_count,
  output logic [EVT_W-1:0]      event_count,
  output logic [CNT_W-1:0]      trigger_latency,
  output logic [CNT_W-1:0]      reject_limit,
  output logic                  hit_reject,
  output logic                  fifo_valid,
  input  wire logic             fifo_ready,
  output logic [CNT_W+EVT_W-1:0] fifo_data,
  output logic                  fifo_full,
  output logic                  fifo_empty,
  output logic                  trigger_lost
);
  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [PIN_COUNT-1:0] sync1;
  logic [PIN_COUNT-1:0] sync2;
  ttca_cmd_if           cmd ();

  // two flops on every pin input
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {encoded_control, event_reset, bunch_reset, trigger};
      sync2 <= sync1;
    end
  end

  ttca_decoder u_dec (
    .clock   (clock),
    .reset_n (reset_n),
    .line    (sync2[PIN_ENCODED]),
    .cmd     (cmd)
  );

  logic do_trigger;
  logic do_bunch;
  logic do_event;
  logic clr;

  assign clr        = !reset_n || (enable_master_reset_code && cmd.master);
  assign do_trigger = (enable_direct_trigger && sync2[PIN_TRIGGER])
                      || cmd.trigger;
  assign do_bunch   = (enable_direct_bunch_reset && sync2[PIN_BUNCH])
                      || cmd.bunch;
  assign do_event   = (enable_direct_event_reset && sync2[PIN_EVENT])
                      || cmd.event_rst;

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v,
                                            input logic [CNT_W-1:0] wrap);
    step = (v == wrap) ? CNT_RESET : CNT_W'(v + 1'b1);
  endfunction

  // all counters advance on the rising edge, preset on bunch reset
  always_ff @(posedge clock) begin
    if (clr) begin
      coarse_count      <= CNT_RESET;
      trigger_tag_count <= CNT_RESET;
      reject_count      <= CNT_RESET;
    end else if (do_bunch) begin
      coarse_count      <= coarse_count_offset;
      trigger_tag_count <= trigger_count_offset;
      reject_count      <= reject_count_offset;
    end else begin
      coarse_count      <= step(coarse_count, count_roll_over);
      trigger_tag_count <= step(trigger_tag_count, count_roll_over);
      reject_count      <= step(reject_count, count_roll_over);
    end
  end

  // delayed coarse count as seen by hit measurement
  logic [CNT_W-1:0] hit_pipe [HIT_REF_CYCLES];
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < HIT_REF_CYCLES; i++)
        hit_pipe[i] <= CNT_RESET;
    end else begin
      hit_pipe[0] <= coarse_count;
      for (int i = 1; i < HIT_REF_CYCLES; i++)
        hit_pipe[i] <= hit_pipe[i-1];
    end
  end
  assign hit_ref_count = hit_pipe[HIT_REF_CYCLES-1];

  // event number counter
  always_ff @(posedge clock) begin
    if (clr || do_event)
      event_count <= EVT_RESET;
    else if (do_trigger)
      event_count <= EVT_W'(event_count + 1'b1);
  end

  // latency and reject limit, modulo 4096
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      trigger_latency <= CNT_RESET;
      reject_limit    <= CNT_RESET;
    end else begin
      trigger_latency <= CNT_W'(coarse_count_offset - trigger_count_offset);
      reject_limit    <= CNT_W'(coarse_count_offset - reject_count_offset);
    end
  end

  // stored measurement has aged past the limit
  always_ff @(posedge clock) begin
    if (clr)
      hit_reject <= 1'b0;
    else
      hit_reject <= enable_automatic_reject
                    && (hit_coarse == reject_count);
  end

  // trigger fifo
  logic [CNT_W+EVT_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]       wr_ptr;
  logic [PTR_W-1:0]       rd_ptr;
  logic [PTR_W:0]         fill;
  logic                   push;
  logic                   pop;

  assign fifo_full  = (fill == (PTR_W+1)'(DEPTH));
  assign fifo_empty = (fill == '0);
  assign fifo_valid = !fifo_empty;
  assign pop        = fifo_valid && fifo_ready;
  assign push       = do_trigger && (!fifo_full || pop);
  assign fifo_data  = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push)
      mem[wr_ptr] <= {event_count, trigger_tag_count};
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push)
        wr_ptr <= PTR_W'(wr_ptr + 1'b1);
      if (pop)
        rd_ptr <= PTR_W'(rd_ptr + 1'b1);
      if (push && !pop)
        fill <= (PTR_W+1)'(fill + 1'b1);
      else if (pop && !push)
        fill <= (PTR_W+1)'(fill - 1'b1);
    end
  end

  // pulse when a trigger finds the fifo full with no pop in the same cycle
  always_ff @(posedge clock) begin
    if (clr)
      trigger_lost <= 1'b0;
    else
      trigger_lost <= do_trigger && !push;
  end
endmodule

// [ttca_pkg.sv]
// constants for the time tag counter alignment block
// Function
// - rising clock edge is the time base
// - bunch reset loads coarse counter preset
// - bunch reset presets coarse, tag, reject together
// - latency is coarse minus tag preset mod 4096
// - coarse minus reject preset is age limit
// - hit two periods after bunch reset reads zero
// - event reset clears event number counter
// - trigger queues tag and event into fifo
// - master reset clears counters and fifo, not the decoder state machine
// - encoded line carries all four commands
// - coarse preset is twelve bit field
// - trigger tag preset is twelve bit field
// - reject preset is twelve bit field
// - counters wrap at programmable twelve bit value
package ttca_pkg;
  localparam int CNT_W          = 12;
  localparam int EVT_W          = 12;
  localparam int FIFO_DEPTH     = 8;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int HIT_REF_NS     = 55;
  localparam int HIT_REF_CYCLES = HIT_REF_NS / CLK_PERIOD_NS + 1;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  localparam logic [EVT_W-1:0] EVT_RESET = 12'h000;
  localparam logic [1:0] CMD_TRIGGER = 2'h0;
  localparam logic [1:0] CMD_BUNCH   = 2'h1;
  localparam logic [1:0] CMD_EVENT   = 2'h2;
  localparam logic [1:0] CMD_MASTER  = 2'h3;
  localparam int PIN_TRIGGER = 0;
  localparam int PIN_BUNCH   = 1;
  localparam int PIN_EVENT   = 2;
  localparam int PIN_ENCODED = 3;
  localparam int PIN_COUNT   = 4;
  typedef enum logic [1:0] {
    TTCA_IDLE = 2'b00,
    TTCA_BIT1 = 2'b01,
    TTCA_BIT2 = 2'b10
  } ttca_dec_e;
endpackage

// [ttca_cmd_if.sv]
// decoded command pulses between decoder and counter core
interface ttca_cmd_if;
  logic trigger;
  logic bunch;
  logic event_rst;
  logic master;
  modport dec  (output trigger, output bunch, output event_rst,
                output master);
  modport core (input trigger, input bunch, input event_rst,
                input master);
endinterface

// [ttca_decoder.sv]
// serial decoder of the encoded command line
module ttca_decoder
  import ttca_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic line,
  ttca_cmd_if.dec   cmd
);
  ttca_dec_e  state;
  logic       first;

  // start bit then two code bits, msb first
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= TTCA_IDLE;
      first <= 1'b0;
    end else begin
      unique case (state)
        TTCA_IDLE: if (line) state <= TTCA_BIT1;
        TTCA_BIT1: begin
          first <= line;
          state <= TTCA_BIT2;
        end
        TTCA_BIT2: state <= TTCA_IDLE;
        default:   state <= TTCA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cmd.trigger   <= 1'b0;
      cmd.bunch     <= 1'b0;
      cmd.event_rst <= 1'b0;
      cmd.master    <= 1'b0;
    end else begin
      cmd.trigger   <= (state == TTCA_BIT2) && ({first, line} == CMD_TRIGGER);
      cmd.bunch     <= (state == TTCA_BIT2) && ({first, line} == CMD_BUNCH);
      cmd.event_rst <= (state == TTCA_BIT2) && ({first, line} == CMD_EVENT);
      cmd.master    <= (state == TTCA_BIT2) && ({first, line} == CMD_MASTER);
    end
  end
endmodule

// [ttca_monitor.sv]
// assertion checker for the counter block
module ttca_monitor
  import ttca_pkg::*;
(
  input wire logic clock, reset_n, trigger, bunch_reset, fifo_ready,
  input wire logic enable_direct_trigger, enable_direct_bunch_reset,
  input wire logic enable_automatic_reject, fifo_valid, fifo_full,
  input wire logic fifo_empty, trigger_lost, hit_reject,
  input wire logic [CNT_W-1:0] coarse_count_offset, trigger_count_offset,
  input wire logic [CNT_W-1:0] reject_count_offset, count_roll_over,
  input wire logic [CNT_W-1:0] hit_coarse, coarse_count, hit_ref_count,
  input wire logic [CNT_W-1:0] trigger_tag_count, reject_count,
  input wire logic [CNT_W-1:0] trigger_latency, reject_limit,
  input wire logic [EVT_W-1:0] event_count,
  input wire logic [CNT_W+EVT_W-1:0] fifo_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_bunch;
    enable_direct_bunch_reset && bunch_reset |-> ##3
      coarse_count == coarse_count_offset &&
      trigger_tag_count == trigger_count_offset &&
      reject_count == reject_count_offset;
  endproperty
  a_bunch: assert property (p_bunch) else $error("no preset");
  property p_step;
    $past(reset_n) && coarse_count != coarse_count_offset |->
      coarse_count == ($past(coarse_count) == $past(count_roll_over) ?
                       12'h000 : $past(coarse_count) + 12'h001);
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_lat;
    $past(reset_n) && $stable(coarse_count_offset) &&
      $stable(trigger_count_offset) |->
      trigger_latency == coarse_count_offset - trigger_count_offset;
  endproperty
  a_lat: assert property (p_lat) else $error("bad latency");
  property p_lim;
    $past(reset_n) && $stable(coarse_count_offset) &&
      $stable(reject_count_offset) |->
      reject_limit == coarse_count_offset - reject_count_offset;
  endproperty
  a_lim: assert property (p_lim) else $error("bad limit");
  property p_push;
    enable_direct_trigger && trigger && !$past(trigger) && fifo_empty &&
      !fifo_ready |-> ##3 fifo_valid &&
      fifo_data[11:0] == $past(trigger_tag_count) &&
      fifo_data[23:12] == $past(event_count);
  endproperty
  a_push: assert property (p_push) else $error("bad entry");
  property p_lost;
    (enable_direct_trigger && trigger && fifo_full && !fifo_ready)
      ##1 !fifo_ready [*2] |-> ##[1:2] trigger_lost;
  endproperty
  a_lost: assert property (p_lost) else $error("no lost");
  property p_ref;
    $past(reset_n) && $past(reset_n, 2) |->
      hit_ref_count == $past(coarse_count, 2);
  endproperty
  a_ref: assert property (p_ref) else $error("bad ref");
  property p_rej;
    enable_automatic_reject && hit_coarse == reject_count |=> hit_reject;
  endproperty
  a_rej: assert property (p_rej) else $error("no reject");
  c_lost: cover property (trigger_lost);
  c_full: cover property (fifo_full);
  c_rej: cover property (hit_reject);
endmodule

bind ttca_core ttca_monitor u_mon (.*);

// [ttca_ctrl_model.sv]
// model of the trigger and timing distribution
module ttca_ctrl_model (
  input  wire logic clock,
  output logic      trigger,
  output logic      bunch_reset,
  output logic      event_reset,
  output logic      encoded_control
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {trigger, bunch_reset, event_reset, encoded_control} = 4'h0;
  end
  // direct pins held high for n cycles
  task automatic pins(input logic [2:0] v, input int n);
    @(negedge clock);
    {event_reset, bunch_reset, trigger} = v;
    repeat (n) @(negedge clock);
    {event_reset, bunch_reset, trigger} = 3'h0;
  endtask
  // start bit, code msb first, back to idle
  task automatic frame(input logic [1:0] c);
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      encoded_control = (i == 0) ? 1'b1 : (i < 3) ? c[2-i] : 1'b0;
    end
  endtask
endmodule

// [ttca_core_tb.sv]
// testbench for the counter block
module ttca_core_tb
  import ttca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n, trigger, bunch_reset, event_reset, encoded_control;
  logic enable_direct_trigger, enable_direct_bunch_reset, fifo_ready;
  logic enable_direct_event_reset, enable_master_reset_code;
  logic enable_automatic_reject, hit_reject, fifo_valid, fifo_full;
  logic fifo_empty, trigger_lost;
  logic [CNT_W-1:0] coarse_count_offset, trigger_count_offset, hit_coarse;
  logic [CNT_W-1:0] reject_count_offset, count_roll_over, coarse_count;
  logic [CNT_W-1:0] hit_ref_count, trigger_tag_count, reject_count;
  logic [CNT_W-1:0] trigger_latency, reject_limit;
  logic [EVT_W-1:0] event_count;
  logic [CNT_W+EVT_W-1:0] fifo_data;
  int bad_count, n_tests, n_lost;
  ttca_core dut (.*);
  ttca_ctrl_model ctl (.clock, .trigger, .bunch_reset, .event_reset,
    .encoded_control);
  initial begin
    forever #20 clock = ~clock;
  end
  always @(negedge clock) if (trigger_lost === 1'b1) n_lost++;
  task automatic chk(input string n, input logic [23:0] e, s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_bunch;
    ctl.pins(3'b010, 1);
    repeat (2) @(negedge clock);
    chk("coarse", 12'h000, coarse_count);
    chk("tag", 12'hf00, trigger_tag_count);
    chk("reject", 12'hef8, reject_count);
    repeat (5) @(negedge clock);
    chk("step", 12'hf05, trigger_tag_count);
    chk("ref", 12'h003, hit_ref_count);
    chk("latency", 12'h100, trigger_latency);
    chk("limit", 12'h108, reject_limit);
  endtask
  task automatic t_reject;
    int i;
    hit_coarse = 12'hf04;
    for (i = 0; i < 12 && hit_reject !== 1'b1; i++) @(negedge clock);
    chk("hit reject", 1, hit_reject);
    if (i == 12) final_report;
  endtask
  task automatic t_fill;
    ctl.pins(3'b110, 1);
    ctl.pins(3'b001, 8);
    repeat (2) @(negedge clock);
    ctl.pins(3'b001, 1);
    repeat (3) @(negedge clock);
    chk("full", 1, fifo_full);
    chk("events", 12'h009, event_count);
    chk("lost", 1, 24'(n_lost));
    fifo_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk("entry event", 12'(i), fifo_data[23:12]);
      chk("entry tag", 12'hf01 + 12'(i), fifo_data[11:0]);
      @(negedge clock);
    end
    fifo_ready = 1'b0;
    chk("empty", 1, fifo_empty);
  endtask
  task automatic t_wrap;
    coarse_count_offset = 12'h005;
    count_roll_over = 12'h020;
    ctl.pins(3'b010, 1);
    repeat (32) @(negedge clock);
    chk("wrap", 12'h002, coarse_count);
    count_roll_over = 12'hfff;
  endtask
  task automatic t_enc;
    enable_master_reset_code = 1'b1;
    ctl.frame(CMD_TRIGGER);
    repeat (8) @(negedge clock);
    chk("enc trigger", 1, fifo_valid);
    ctl.frame(CMD_EVENT);
    repeat (8) @(negedge clock);
    chk("enc event", 12'h000, event_count);
    coarse_count_offset = 12'h800;
    ctl.frame(CMD_BUNCH);
    repeat (8) @(negedge clock);
    chk("enc bunch", 8'h80, coarse_count[11:4]);
    coarse_count_offset = 12'h000;
    ctl.frame(CMD_MASTER);
    repeat (8) @(negedge clock);
    chk("enc master", 1, fifo_empty);
    chk("enc count", 8'h00, coarse_count[11:4]);
  endtask
  initial begin
    {reset_n, fifo_ready, enable_master_reset_code} = 3'h0;
    {enable_direct_trigger, enable_direct_bunch_reset} = 2'h3;
    {enable_direct_event_reset, enable_automatic_reject} = 2'h3;
    coarse_count_offset = 12'h000;
    trigger_count_offset = 12'hf00;
    reject_count_offset = 12'hef8;
    count_roll_over = 12'hfff;
    hit_coarse = 12'h000;
    {bad_count, n_tests, n_lost} = '0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk("reset empty", 1, fifo_empty);
    t_bunch();
    t_reject();
    t_fill();
    t_wrap();
    t_enc();
    final_report();
  end
endmodule
